/* hw/sequencer_defines.vh */
// Shared constants for the regulator power sequencer: register indexes, reset values,
// field positions and timing counts.
// Assumes a 250 MHz system clock; register indexes double as I2C register pointers.
`ifndef SEQUENCER_DEFINES_VH
`define SEQUENCER_DEFINES_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     4
`define TICK_TIME_US      500
`define DEGLITCH_TIME_US  1000
`define TICK_CYCLES       ((`TICK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define DEGLITCH_CYCLES   ((`DEGLITCH_TIME_US * 1000) / `CLK_PERIOD_NS)

// Delays in half-millisecond ticks
`define DLY_0MS    5'h00
`define DLY_0P5MS  5'h01
`define DLY_1MS    5'h02
`define DLY_1P5MS  5'h03
`define DLY_2MS    5'h04
`define DLY_3MS    5'h06
`define DLY_5MS    5'h0A
`define DLY_6MS    5'h0C
`define DLY_10MS   5'h14
`define DLY_11MS   5'h16
`define TICK_SAT   5'h1F

// ----------------------------------------------------------------------------
// Register indexes (AXI byte address = index * 4)
// ----------------------------------------------------------------------------
`define IDX_SYS_CTRL    8'h07
`define IDX_OUT_ENABLE  8'h10
`define IDX_OUT_STATUS  8'h11
`define IDX_STEP_A_VOLT 8'h23
`define IDX_STEP_B_VOLT 8'h29

// System control fields
`define SC_DELAY_SET_HI 6
`define SC_DELAY_SET_LO 4
`define SC_FORCE_PWM_B  2
`define SC_FORCE_PWM_A  1
`define SC_EXT_CLK      0
`define SYS_CTRL_RST    8'h28
`define SYS_CTRL_MASK   8'h77
`define SYS_CTRL_FIXED  8'h08

`define OUT_ENABLE_RST   4'hF
`define STEP_A_VOLT_RST  8'h0A
`define STEP_B_VOLT_RST  8'h14

`define I2C_SLAVE_ADDR  7'h60
`define AXI_OKAY        2'b00
`define AXI_SLVERR      2'b10

`endif

/* hw/sync_two_flop.v */
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level from another domain; no bus coherency is implied.
`default_nettype none

module sync_two_flop #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      stage1_q <= {WIDTH{1'b0}};
      syncOut  <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule // sync_two_flop

`default_nettype wire

/* hw/delay_gate.v */
// One regulator's sequenced enable: turns on or off once the shared tick count
// reaches the regulator's delay for the running sequence.
// Assumes tickCount restarts from zero in the same edge that the mode changes.
`default_nettype none

module delay_gate (
  input  wire       ref_clk,
  input  wire       reset,
  input  wire       runOn,
  input  wire       runOff,
  input  wire [4:0] tickCount,
  input  wire [4:0] onDelay,
  input  wire [4:0] offDelay,
  output reg        gateOn
);

  always @(posedge ref_clk)
  begin
    if (reset)
      gateOn <= 1'b0;
    else if (runOn && (tickCount >= onDelay))
      gateOn <= 1'b1;
    else if (runOff && (tickCount >= offDelay))
      gateOn <= 1'b0;
  end

endmodule // delay_gate

`default_nettype wire

/* hw/regulator_power_sequencer.v */
// Power sequencer control for two step-down converters and two linear regulators,
// with an I2C slave on sampled pins and an AXI4-Lite register slave.
// Assumes reset is the power-on reset; pins and SCL/SDA are asynchronous levels.
//
// Summary of operation
// - Step-downs enabled by default after power-on
// - Step-down voltages reload defaults when on sequence turns all four rails on
// - Mode bit one forces PWM operation
// - Shutdown: high side off, low side discharges
// - Soft start only on enable rise, supply ok
// - Current limit steps through four levels
// - Each regulator has its own enable pin
// - Trigger rise powers on, fall powers off
// - Trigger deglitched for one millisecond
// - Pins ignored while trigger high
// - Default on delays 1.5, 2, 3, 6 ms
// - On delays selectable from six values
// - Off delays measured from trigger fall
// - Off delays selectable, default equal on delays
// - On equals host enable and (pin or trigger)
// - Power-on reset initialises all logic
// - I2C slave sampled from incoming SCL
// - SDA changes with SCL low; start, stop
// - Repeated start handled like first start
// - Three-bit delay set selects on delays
`include "sequencer_defines.vh"
`default_nettype none

module regulator_power_sequencer #(
  parameter [17:0] TICK_CYCLES     = `TICK_CYCLES,
  parameter [17:0] DEGLITCH_CYCLES = `DEGLITCH_CYCLES,
  parameter [4:0]  OFF_DLY_STEP_A  = `DLY_1P5MS,
  parameter [4:0]  OFF_DLY_STEP_B  = `DLY_2MS,
  parameter [4:0]  OFF_DLY_LIN_A   = `DLY_3MS,
  parameter [4:0]  OFF_DLY_LIN_B   = `DLY_6MS
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        step_down_a_enable_pin,
  input  wire        step_down_b_enable_pin,
  input  wire        linear_a_enable_pin,
  input  wire        linear_b_enable_pin,
  input  wire        sequenceTrigger,
  input  wire        supplyOk,
  input  wire        scl,
  input  wire        sdaIn,
  output reg         sdaOut,
  output reg         sdaOeN,
  output reg  [3:0]  regulatorOn,
  output reg  [1:0]  stepDownRun,
  output reg  [1:0]  stepDownDischarge,
  output reg  [3:0]  currentLimitStep,
  output reg  [1:0]  forcePwm,
  output reg  [7:0]  stepDownAVoltage,
  output reg  [7:0]  stepDownBVoltage,
  input  wire        awvalid,
  output reg         awready,
  input  wire [9:0]  awaddr,
  input  wire        wvalid,
  output reg         wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  input  wire        arvalid,
  output reg         arready,
  input  wire [9:0]  araddr,
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp
);

  localparam [1:0] SEQ_IDLE = 2'd0;
  localparam [1:0] SEQ_ON   = 2'd1;
  localparam [1:0] SEQ_OFF  = 2'd2;

  localparam [2:0] I2C_IDLE = 3'd0;
  localparam [2:0] I2C_ADDR = 3'd1;
  localparam [2:0] I2C_REG  = 3'd2;
  localparam [2:0] I2C_DATA = 3'd3;
  localparam [2:0] I2C_READ = 3'd4;

  // ----------------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------------
  wire [7:0] syncIn;

  sync_two_flop #(.WIDTH(8)) inputSync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .asyncIn ({supplyOk, sdaIn, scl, sequenceTrigger, linear_b_enable_pin,
               linear_a_enable_pin, step_down_b_enable_pin, step_down_a_enable_pin}),
    .syncOut (syncIn)
  );

  wire [3:0] pinEn    = syncIn[3:0];
  wire       trigSync = syncIn[4];
  wire       sclS     = syncIn[5];
  wire       sdaS     = syncIn[6];
  wire       supplyS  = syncIn[7];

  // ----------------------------------------------------------------------------
  // Registers and shared read path
  // ----------------------------------------------------------------------------
  reg  [7:0] sysCtrl_q;
  reg  [3:0] hostEn_q;
  reg  [1:0] seqMode_q;
  reg        i2cWe_q;
  reg  [7:0] i2cWrIdx_q;
  reg  [7:0] i2cWrData_q;
  reg        seqDone_q;

  function isMapped;
    input [7:0] idx;
    begin
      isMapped = (idx == `IDX_SYS_CTRL) || (idx == `IDX_OUT_ENABLE) ||
                 (idx == `IDX_OUT_STATUS) || (idx == `IDX_STEP_A_VOLT) ||
                 (idx == `IDX_STEP_B_VOLT);
    end
  endfunction

  function [7:0] readReg;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_SYS_CTRL:    readReg = sysCtrl_q | `SYS_CTRL_FIXED;
        `IDX_OUT_ENABLE:  readReg = {4'h0, hostEn_q};
        `IDX_OUT_STATUS:  readReg = {2'b00, seqMode_q, regulatorOn};
        `IDX_STEP_A_VOLT: readReg = stepDownAVoltage;
        `IDX_STEP_B_VOLT: readReg = stepDownBVoltage;
        default:          readReg = 8'h00;
      endcase
    end
  endfunction

  // AXI writes wait while an I2C write is being applied, so neither is lost
  reg        awHeld_q;
  reg        wHeld_q;
  reg  [7:0] awIdx_q;
  reg  [7:0] wData_q;
  reg        wLane0_q;
  wire       axiDo  = awHeld_q && wHeld_q && !bvalid && !i2cWe_q;
  wire       axiWe  = axiDo && wLane0_q && isMapped(awIdx_q);
  wire       anyWe  = i2cWe_q || axiWe;
  wire [7:0] wrIdx  = i2cWe_q ? i2cWrIdx_q : awIdx_q;
  wire [7:0] wrData = i2cWe_q ? i2cWrData_q : wData_q;

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      sysCtrl_q        <= `SYS_CTRL_RST;
      hostEn_q         <= `OUT_ENABLE_RST;
      stepDownAVoltage <= `STEP_A_VOLT_RST;
      stepDownBVoltage <= `STEP_B_VOLT_RST;
      forcePwm         <= 2'b00;
    end
    else
    begin
      if (anyWe && (wrIdx == `IDX_SYS_CTRL))
        sysCtrl_q <= wrData & `SYS_CTRL_MASK;
      if (anyWe && (wrIdx == `IDX_OUT_ENABLE))
        hostEn_q <= wrData[3:0];
      // Reload takes precedence over a write in the same cycle
      if (seqDone_q)
      begin
        stepDownAVoltage <= `STEP_A_VOLT_RST;
        stepDownBVoltage <= `STEP_B_VOLT_RST;
      end
      else
      begin
        if (anyWe && (wrIdx == `IDX_STEP_A_VOLT))
          stepDownAVoltage <= wrData;
        if (anyWe && (wrIdx == `IDX_STEP_B_VOLT))
          stepDownBVoltage <= wrData;
      end
      forcePwm <= {sysCtrl_q[`SC_FORCE_PWM_B], sysCtrl_q[`SC_FORCE_PWM_A]};
    end
  end

  // ----------------------------------------------------------------------------
  // Trigger deglitch and sequence timing
  // ----------------------------------------------------------------------------
  reg  [17:0] glitchCnt_q;
  reg         trigFilt_q;
  reg  [17:0] tickDiv_q;
  reg  [4:0]  tickCount_q;
  wire        trigAccept = (trigSync != trigFilt_q) &&
                           (glitchCnt_q == DEGLITCH_CYCLES - 18'd1);
  wire        tickNow    = (tickDiv_q == TICK_CYCLES - 18'd1);

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      glitchCnt_q <= 18'h00000;
      trigFilt_q  <= 1'b0;
      seqMode_q   <= SEQ_IDLE;
      tickDiv_q   <= 18'h00000;
      tickCount_q <= 5'h00;
    end
    else
    begin
      if (trigSync == trigFilt_q)
        glitchCnt_q <= 18'h00000;
      else if (trigAccept)
        glitchCnt_q <= 18'h00000;
      else
        glitchCnt_q <= glitchCnt_q + 18'd1;
      if (trigAccept)
      begin
        // Either edge restarts timing from zero, aborting any running sequence
        trigFilt_q  <= trigSync;
        seqMode_q   <= trigSync ? SEQ_ON : SEQ_OFF;
        tickDiv_q   <= 18'h00000;
        tickCount_q <= 5'h00;
      end
      else
      begin
        tickDiv_q <= tickNow ? 18'h00000 : tickDiv_q + 18'd1;
        if (tickNow && (tickCount_q != `TICK_SAT))
          tickCount_q <= tickCount_q + 5'd1;
      end
    end
  end

  function [19:0] onDelays;
    input [2:0] sel;
    begin
      case (sel)
        3'b000:  onDelays = {`DLY_1MS, `DLY_1MS, `DLY_1MS, `DLY_1MS};
        3'b001:  onDelays = {`DLY_2MS, `DLY_2MS, `DLY_1P5MS, `DLY_1MS};
        3'b010:  onDelays = {`DLY_6MS, `DLY_3MS, `DLY_2MS, `DLY_1P5MS};
        3'b011:  onDelays = {`DLY_11MS, `DLY_6MS, `DLY_3MS, `DLY_2MS};
        3'b100:  onDelays = {`DLY_6MS, `DLY_3MS, `DLY_2MS, `DLY_1MS};
        3'b101:  onDelays = {`DLY_11MS, `DLY_11MS, `DLY_6MS, `DLY_3MS};
        3'b110:  onDelays = {`DLY_11MS, `DLY_11MS, `DLY_11MS, `DLY_6MS};
        default: onDelays = {`DLY_11MS, `DLY_11MS, `DLY_11MS, `DLY_11MS};
      endcase
    end
  endfunction

  wire [19:0] onSet  = onDelays(sysCtrl_q[`SC_DELAY_SET_HI:`SC_DELAY_SET_LO]);
  wire [19:0] offSet = {OFF_DLY_LIN_B, OFF_DLY_LIN_A, OFF_DLY_STEP_B, OFF_DLY_STEP_A};
  wire [3:0]  seqEn;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gates
      delay_gate seqGate (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .runOn     (seqMode_q == SEQ_ON),
        .runOff    (seqMode_q == SEQ_OFF),
        .tickCount (tickCount_q),
        .onDelay   (onSet[g*5 +: 5]),
        .offDelay  (offSet[g*5 +: 5]),
        .gateOn    (seqEn[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Regulator enables, shutdown and soft start
  // ----------------------------------------------------------------------------
  // With the trigger high the pins are masked; the sequence gates turn the rails on
  wire [3:0] regOnD = hostEn_q & (trigFilt_q ? seqEn : (pinEn | seqEn));
  reg  [1:0] softActive_q;
  integer    i;

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      regulatorOn       <= 4'h0;
      stepDownRun       <= 2'b00;
      stepDownDischarge <= 2'b11;
      currentLimitStep  <= 4'h0;
      softActive_q      <= 2'b00;
      seqDone_q         <= 1'b0;
    end
    else
    begin
      regulatorOn       <= regOnD;
      stepDownRun       <= regOnD[1:0];
      stepDownDischarge <= ~regOnD[1:0];
      seqDone_q <= (seqMode_q == SEQ_ON) && (&seqEn) && !(&regulatorOn) && (&regOnD);
      for (i = 0; i < 2; i = i + 1)
      begin
        if (regOnD[i] && !regulatorOn[i])
        begin
          // Without a good supply at the enable edge the limit goes straight to full
          softActive_q[i]           <= supplyS;
          currentLimitStep[i*2 +: 2] <= supplyS ? 2'd0 : 2'd3;
        end
        else if (!regOnD[i])
        begin
          softActive_q[i]           <= 1'b0;
          currentLimitStep[i*2 +: 2] <= 2'd0;
        end
        else if (softActive_q[i] && tickNow)
        begin
          currentLimitStep[i*2 +: 2] <= currentLimitStep[i*2 +: 2] + 2'd1;
          if (currentLimitStep[i*2 +: 2] == 2'd2)
            softActive_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // I2C slave on sampled SCL and SDA
  // ----------------------------------------------------------------------------
  reg        sclP_q;
  reg        sdaP_q;
  reg  [2:0] i2cState_q;
  reg  [3:0] bitCnt_q;
  reg  [7:0] shiftIn_q;
  reg  [7:0] shiftOut_q;
  reg  [7:0] regPtr_q;
  reg        masterNack_q;
  wire       startCond = sclS && sclP_q && sdaP_q && !sdaS;
  wire       stopCond  = sclS && sclP_q && !sdaP_q && sdaS;
  wire       sclRise   = sclS && !sclP_q;
  wire       sclFall   = !sclS && sclP_q;

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      sclP_q       <= 1'b1;
      sdaP_q       <= 1'b1;
      i2cState_q   <= I2C_IDLE;
      bitCnt_q     <= 4'h0;
      shiftIn_q    <= 8'h00;
      shiftOut_q   <= 8'h00;
      regPtr_q     <= 8'h00;
      masterNack_q <= 1'b0;
      sdaOut       <= 1'b0;
      sdaOeN       <= 1'b1;
      i2cWe_q      <= 1'b0;
      i2cWrIdx_q   <= 8'h00;
      i2cWrData_q  <= 8'h00;
    end
    else
    begin
      sclP_q  <= sclS;
      sdaP_q  <= sdaS;
      i2cWe_q <= 1'b0;
      if (startCond)
      begin
        i2cState_q   <= I2C_ADDR;
        bitCnt_q     <= 4'h0;
        masterNack_q <= 1'b0;
        sdaOeN       <= 1'b1;
      end
      else if (stopCond)
      begin
        i2cState_q <= I2C_IDLE;
        sdaOeN     <= 1'b1;
      end
      else if (i2cState_q != I2C_IDLE)
      begin
        if (sclRise && (bitCnt_q < 4'd8))
        begin
          shiftIn_q <= {shiftIn_q[6:0], sdaS};
          bitCnt_q  <= bitCnt_q + 4'd1;
        end
        else if (sclRise && (bitCnt_q == 4'd9) && (i2cState_q == I2C_READ))
          masterNack_q <= sdaS;
        else if (sclFall && (bitCnt_q == 4'd8))
        begin
          bitCnt_q <= 4'd9;
          sdaOeN   <= 1'b0;
          case (i2cState_q)
            I2C_ADDR:
            begin
              if (shiftIn_q[7:1] == `I2C_SLAVE_ADDR)
                i2cState_q <= shiftIn_q[0] ? I2C_READ : I2C_REG;
              else
              begin
                i2cState_q <= I2C_IDLE;
                sdaOeN     <= 1'b1;
              end
            end
            I2C_REG:
            begin
              regPtr_q   <= shiftIn_q;
              i2cState_q <= I2C_DATA;
            end
            I2C_DATA:
            begin
              i2cWe_q     <= 1'b1;
              i2cWrIdx_q  <= regPtr_q;
              i2cWrData_q <= shiftIn_q;
              regPtr_q    <= regPtr_q + 8'd1;
            end
            default: sdaOeN <= 1'b1;
          endcase
        end
        else if (sclFall && (bitCnt_q == 4'd9))
        begin
          bitCnt_q <= 4'h0;
          sdaOeN   <= 1'b1;
          if ((i2cState_q == I2C_READ) && masterNack_q)
            i2cState_q <= I2C_IDLE;
          else if (i2cState_q == I2C_READ)
          begin
            {sdaOeN, shiftOut_q} <= {readReg(regPtr_q), 1'b0};
            regPtr_q   <= regPtr_q + 8'd1;
          end
        end
        else if (sclFall && (i2cState_q == I2C_READ))
        begin
          // SDA only moves while SCL is low
          shiftOut_q <= {shiftOut_q[6:0], 1'b0};
          sdaOeN     <= shiftOut_q[7];
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awIdx_q  <= 8'h00;
      wData_q  <= 8'h00;
      wLane0_q <= 1'b0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= `AXI_OKAY;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h00000000;
      rresp    <= `AXI_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_q <= 1'b1;
        awIdx_q  <= awaddr[9:2];
        awready  <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wHeld_q  <= 1'b1;
        wData_q  <= wdata[7:0];
        wLane0_q <= wstrb[0];
        wready   <= 1'b0;
      end
      if (axiDo)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= isMapped(awIdx_q) ? `AXI_OKAY : `AXI_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h000000, readReg(araddr[9:2])};
        rresp   <= isMapped(araddr[9:2]) ? `AXI_OKAY : `AXI_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // regulator_power_sequencer

`default_nettype wire

/* test/seq_power_sva.sv */
// Concurrent checks on rails, soft start and serial data line timing.
// Bound into regulator_power_sequencer; sees only its ports.
`default_nettype none
module seq_power_sva #(
  parameter [17:0] DEGLITCH_CYCLES = 18'h28
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       step_down_b_enable_pin,
  input wire logic       linear_b_enable_pin,
  input wire logic       sequenceTrigger,
  input wire logic       supplyOk,
  input wire logic       scl,
  input wire logic       sdaOeN,
  input wire logic [3:0] regulatorOn,
  input wire logic [1:0] stepDownRun,
  input wire logic [1:0] stepDownDischarge,
  input wire logic [3:0] currentLimitStep
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ---
  // Trigger age
  // ---
  // Raw trigger high time; saturates rather than wrapping
  logic [19:0] trigHi;
  always_ff @(posedge ref_clk)
    if (reset || !sequenceTrigger)
      trigHi <= 20'h0;
    else if (trigHi != 20'hFFFFF)
      trigHi <= trigHi + 20'h1;

  reset_clear_a: assert property (disable iff (1'h0) reset |=> regulatorOn == 4'h0 && sdaOeN)
    else $error("rails or data line active after reset");
  disch_tie_a: assert property (stepDownDischarge == ~stepDownRun)
    else $error("discharge not opposite of run");
  soft_zero_a: assert property ($rose(regulatorOn[0]) && supplyOk |-> currentLimitStep[1:0] == 2'h0)
    else $error("soft start did not begin at lowest limit");
  limit_step_a: assert property (supplyOk && stepDownRun[0] && $past(stepDownRun[0])
      && $past(currentLimitStep[1:0]) != 2'h3 && currentLimitStep[1:0] != $past(currentLimitStep[1:0])
      |-> currentLimitStep[1:0] == $past(currentLimitStep[1:0]) + 2'h1)
    else $error("current limit skipped a step");
  deglitch_a: assert property ($rose(regulatorOn[3]) && !linear_b_enable_pin
      && !$past(linear_b_enable_pin, 4) |-> trigHi > DEGLITCH_CYCLES)
    else $error("sequenced rail rose before trigger was filtered");
  trig_hold_a: assert property (trigHi > DEGLITCH_CYCLES + 8
      |-> (~regulatorOn & $past(regulatorOn)) == 4'h0)
    else $error("rail dropped while trigger held high");
  pin_follow_a: assert property ($rose(step_down_b_enable_pin) && !sequenceTrigger
      ##1 (step_down_b_enable_pin && !sequenceTrigger) [*6] |-> regulatorOn[1])
    else $error("rail did not follow its enable pin");
  sda_low_a: assert property ($changed(sdaOeN) |-> !scl)
    else $error("data line changed while clock high");

  cover property ($rose(regulatorOn[3]));
  cover property ($fell(sdaOeN));
  cover property (currentLimitStep[3:2] == 2'h3);
endmodule // seq_power_sva

bind regulator_power_sequencer seq_power_sva #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) checker_i (
  .ref_clk, .reset, .step_down_b_enable_pin, .linear_b_enable_pin, .sequenceTrigger,
  .supplyOk, .scl, .sdaOeN, .regulatorOn, .stepDownRun, .stepDownDischarge, .currentLimitStep);
`default_nettype wire

/* test/serial_host_model.sv */
// Two-wire bus master model; 125 ns bit period.
// Assumes the bench resolves SDA as a pulled-up wired-AND of all pull-downs.
`default_nettype none
module serial_host_model (
  output var logic scl,
  output var logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime Q = 31.25;
  // ---
  // Bus conditions
  // ---
  // Clock rests high between frames, as the pull-up leaves it
  initial
  begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end
  task automatic start();
    sdaLow = 1'h0;
    #Q scl = 1'h1;
    #Q sdaLow = 1'h1;
    #Q scl = 1'h0;
    #Q;
  endtask
  task automatic stop();
    sdaLow = 1'h1;
    #Q scl = 1'h1;
    #Q sdaLow = 1'h0;
    #Q;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaLow = ~b[i];
      #Q scl = 1'h1;
      #(2 * Q) scl = 1'h0;
      #Q;
    end
    sdaLow = 1'h0;
    #Q scl = 1'h1;
    #Q nack = sda;
    #Q scl = 1'h0;
    #Q;
  endtask
endmodule // serial_host_model
`default_nettype wire

/* test/testbench.sv */
// Bench for the power sequencer: AXI4-Lite tasks, pins, trigger, serial host.
// Assumes the design is built with a 20-cycle tick and a 40-cycle trigger filter.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 20;
  localparam int DG = 40;
  localparam int DT [8][4] = '{'{2, 2, 2, 2}, '{2, 3, 4, 4}, '{3, 4, 6, 12}, '{4, 6, 12, 22},
    '{2, 4, 6, 12}, '{6, 12, 22, 22}, '{12, 22, 22, 22}, '{22, 22, 22, 22}};
  localparam int OFF [4] = '{3, 4, 6, 12};
  logic        ref_clk = 1'h0;
  logic        reset = 1'h1;
  logic [3:0]  pin = 4'h0;
  logic        sequenceTrigger = 1'h0;
  logic        supplyOk = 1'h1;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [9:0]  awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0;
  wire logic   awready, wready, bvalid, arready, rvalid, sdaOut, sdaOeN, scl, sdaLow, sda;
  wire logic [1:0]  bresp, rresp, stepDownRun, forcePwm;
  wire logic [3:0]  regulatorOn, currentLimitStep;
  wire logic [7:0]  stepDownAVoltage, stepDownBVoltage;
  wire logic [31:0] rdata;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  always #2 ref_clk = ~ref_clk;
  // Open-drain data line with pull-up
  assign sda = !sdaLow && (sdaOeN || sdaOut);

  serial_host_model host (.scl, .sdaLow, .sda);
  regulator_power_sequencer #(.TICK_CYCLES(18'h14), .DEGLITCH_CYCLES(18'h28)) DUT (
    .ref_clk, .reset, .step_down_a_enable_pin(pin[0]), .step_down_b_enable_pin(pin[1]),
    .linear_a_enable_pin(pin[2]), .linear_b_enable_pin(pin[3]), .sequenceTrigger, .supplyOk,
    .scl, .sdaIn(sda), .sdaOut, .sdaOeN, .regulatorOn, .stepDownRun, .stepDownDischarge(),
    .currentLimitStep, .forcePwm, .stepDownAVoltage, .stepDownBVoltage, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  // ---
  // Tasks
  // ---
  task automatic give_verdict();
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    chk(32'(got), 32'(exp));
  endtask
  task automatic axWr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
    chkResp(bresp, r);
    @(posedge ref_clk);
  endtask
  task automatic axRd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'h0;
    end
    while (!rvalid);
    rready <= 1'h0;
    chk(rdata, d);
    chkResp(rresp, r);
    @(posedge ref_clk);
  endtask
  // Records when each rail reaches lvl; a late pin on the last rail must be ignored
  task automatic watch(input logic lvl, input int d [4]);
    int t [4] = '{-1, -1, -1, -1};
    for (int c = 0; c < 520; c++)
    begin
      @(posedge ref_clk);
      if (c == 60) pin[3] <= lvl;
      if (c == 500) pin[3] <= 1'h0;
      for (int i = 0; i < 4; i++) if (t[i] < 0 && regulatorOn[i] === lvl) t[i] = c;
    end
    for (int i = 0; i < 4; i++)
      chk(32'(t[i] >= DG + (d[i] - 1) * TK && t[i] <= DG + d[i] * TK + 12), 32'h1);
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      give_verdict();
    end
  end
  // ---
  // Main sequence
  // ---
  initial
  begin
    logic nack;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    axRd(10'h01C, 32'h28, 2'h0);
    axRd(10'h040, 32'hF, 2'h0);
    axRd(10'h08C, 32'h0A, 2'h0);
    axRd(10'h3FC, 32'h0, 2'h2);
    axWr(10'h3FC, 32'h0, 2'h2);
    sequenceTrigger <= 1'h1;
    repeat (20) @(posedge ref_clk);
    sequenceTrigger <= 1'h0;
    repeat (300) @(posedge ref_clk);
    chk(32'(regulatorOn), 32'h0);
    pin[0] <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk(32'(regulatorOn), 32'h1);
    repeat (4 * TK) @(posedge ref_clk);
    chk(32'(currentLimitStep[1:0]), 32'h3);
    pin[0] <= 1'h0;
    axWr(10'h040, 32'hE, 2'h0);
    pin[0] <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk(32'(regulatorOn), 32'h0);
    pin[0] <= 1'h0;
    axWr(10'h040, 32'hF, 2'h0);
    supplyOk <= 1'h0;
    repeat (6) @(posedge ref_clk);
    pin[1] <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk(32'(regulatorOn), 32'h2);
    chk(32'(currentLimitStep[3:2]), 32'h3);
    pin[1] <= 1'h0;
    supplyOk <= 1'h1;
    host.start();
    host.sendByte(8'hC2, nack);
    chk(32'(nack), 32'h1);
    host.start();
    host.sendByte(8'hC0, nack);
    chk(32'(nack), 32'h0);
    host.sendByte(8'h07, nack);
    host.sendByte(8'h06, nack);
    chk(32'(nack), 32'h0);
    host.stop();
    @(posedge ref_clk);
    axRd(10'h01C, 32'h0E, 2'h0);
    for (int s = 0; s < 8; s++)
    begin
      axWr(10'h01C, 32'(s * 16 + (s % 4) * 2), 2'h0);
      axWr(s % 2 ? 10'h0A4 : 10'h08C, 32'h33, 2'h0);
      axRd(10'h01C, 32'(s * 16 + (s % 4) * 2 + 8), 2'h0);
      chk(32'(forcePwm), 32'(s % 4));
      sequenceTrigger <= 1'h1;
      watch(1'h1, DT[s]);
      chk(32'({stepDownBVoltage, stepDownAVoltage}), 32'h140A);
      axRd(10'h08C, 32'h0A, 2'h0);
      sequenceTrigger <= 1'h0;
      watch(1'h0, OFF);
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
